// [logic/slcr_cfg.svh]
// constants for the serial link configuration register bank
// Function
// - link control bit 7 starts or stops the serial link; resets to not auto-start pin.
// - reverse channel is unavailable for 350 us after the link starts or stops.
// - link control bit 4 selects sleep mode; reset value derived from two pins.
// - bits 3:2 pick base peripheral: 00 I2C, 01 UART, 10/11 off; reset 00.
// - link control bit 1 enables reverse channel reception; resets to 1.
// - link control bit 0 enables forward channel transmission; resets to 1.
// - drive bit 7 set omits register address in I2C conversion; resets to 0.
// - drive bits 5:4 pick swing 200/300/400 mV; 00 unused; resets to 11.
`ifndef SLCR_CFG_SVH
`define SLCR_CFG_SVH

// register indices; byte address is four times the index
`define SLCR_IDX_LINK_CONTROL 6'h04
`define SLCR_IDX_DRIVE_CONFIG 6'h05
`define SLCR_IDX_RESERVED_SIX 6'h06
`define SLCR_IDX_RESERVED_SEVEN 6'h07
`define SLCR_IDX_STATUS 6'h20

// reset values, pin-derived bits 7 and 4 of link control are zero here
`define SLCR_LINK_RST_BASE 8'h03
`define SLCR_DRIVE_RST 8'h70
`define SLCR_RESERVED_SIX_VAL 8'h40
`define SLCR_RESERVED_SEVEN_VAL 8'h22

// field codes
`define SLCR_BASE_I2C 2'h0
`define SLCR_BASE_UART 2'h1
`define SLCR_SWING_UNUSED 2'h0
`define SLCR_EMPH_OFF 4'h0
`define SLCR_EMPH_DEEMPH_MAX 4'h4
`define SLCR_EMPH_BOOST_MIN 4'h8

// axi responses
`define SLCR_RESP_OKAY 2'h0
`define SLCR_RESP_SLVERR 2'h2

// timing
`define SLCR_CLK_MHZ 125
`define SLCR_BLACKOUT_US 350

`endif

// [logic/slcr_pkg.sv]
// types shared by the serial link configuration register bank
package slcr_pkg;

  typedef struct packed {
    logic serial_link_enable;
    logic config_link_enable;
    logic bit_sequence_test_enable;
    logic sleep_mode;
    logic [1:0] base_peripheral_select;
    logic reverse_channel_enable;
    logic forward_channel_enable;
  } slcr_link_ctrl_s;

  typedef struct packed {
    logic register_address_suppress;
    logic filter_pll_disable;
    logic [1:0] line_swing_level;
    logic [3:0] driver_emphasis_level;
  } slcr_drive_s;

  typedef struct packed {
    logic active;
    logic boost;
    logic [2:0] step;
    logic reserved_code;
  } slcr_emph_s;

  typedef enum logic [1:0] {
    SLCR_T_IDLE = 2'b01,
    SLCR_T_COUNT = 2'b10
  } slcr_timer_e;

endpackage : slcr_pkg

// [logic/slcr_blackout_timer.sv]
// one-shot timer that marks the reverse channel unavailable
`timescale 1ns/1ps
module slcr_blackout_timer
  import slcr_pkg::*;
#(
  parameter int CYCLES = 43750
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic restart,
  output logic busy
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  slcr_timer_e state_ff;
  logic [CW-1:0] count_ff;

  // a new start or stop during the window restarts the full interval
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_ff <= SLCR_T_IDLE;
    end else if (restart) begin
      state_ff <= SLCR_T_COUNT;
    end else begin
      unique case (state_ff)
        SLCR_T_IDLE: state_ff <= SLCR_T_IDLE;
        SLCR_T_COUNT: begin
          if (count_ff == LAST) begin
            state_ff <= SLCR_T_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || restart) begin
      count_ff <= '0;
    end else if (state_ff == SLCR_T_COUNT) begin
      count_ff <= count_ff + 1'b1;
    end
  end

  assign busy = (state_ff == SLCR_T_COUNT);

endmodule : slcr_blackout_timer

// [logic/slcr_regs.sv]
// serial link configuration registers behind an axi4-lite slave
`timescale 1ns/1ps
`include "slcr_cfg.svh"
module slcr_regs
  import slcr_pkg::*;
#(
  parameter int BLACKOUT_CYCLES = `SLCR_BLACKOUT_US * `SLCR_CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic auto_start_pin,
  input wire logic control_direction_pin,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output slcr_link_ctrl_s link_cfg,
  output slcr_drive_s drive_cfg,
  output logic reverse_rx_enable,
  output logic reverse_blackout,
  output logic base_i2c_sel,
  output logic base_uart_sel,
  output logic line_swing_invalid,
  output slcr_emph_s emphasis
);

  // decode of a byte address into a known register
  function automatic logic idx_known(input logic [7:0] addr);
    logic [5:0] idx;
    idx = addr[7:2];
    return (idx == `SLCR_IDX_LINK_CONTROL) || (idx == `SLCR_IDX_DRIVE_CONFIG) ||
           (idx == `SLCR_IDX_RESERVED_SIX) || (idx == `SLCR_IDX_RESERVED_SEVEN) ||
           (idx == `SLCR_IDX_STATUS);
  endfunction : idx_known

  function automatic slcr_emph_s emph_decode(input logic [3:0] code);
    slcr_emph_s d;
    d = '0;
    if (code == `SLCR_EMPH_OFF) begin
      d = '0;
    end else if (code <= `SLCR_EMPH_DEEMPH_MAX) begin
      d.active = 1'b1;
      d.step = code[2:0];
    end else if (code >= `SLCR_EMPH_BOOST_MIN) begin
      d.active = 1'b1;
      d.boost = 1'b1;
      d.step = code[2:0];
    end else begin
      d.reserved_code = 1'b1;
    end
    return d;
  endfunction : emph_decode

  slcr_link_ctrl_s link_ff;
  slcr_drive_s drive_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb0_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic link_prev_ff;
  logic base_i2c_ff;
  logic base_uart_ff;
  logic swing_bad_ff;
  slcr_emph_s emph_ff;
  logic do_write;
  logic wr_link;
  logic wr_drive;
  logic link_toggle;
  logic busy;
  logic [7:0] rd_byte;
  logic [5:0] rd_idx;

  // write channel: address and data taken in either order, response after both
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_link = do_write && wstrb0_ff && (awaddr_ff[7:2] == `SLCR_IDX_LINK_CONTROL);
  assign wr_drive = do_write && wstrb0_ff && (awaddr_ff[7:2] == `SLCR_IDX_DRIVE_CONFIG);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      w_got_ff <= 1'b0;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_ff <= 1'b1;
      wdata_ff <= s_axi_wdata[7:0];
      wstrb0_ff <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `SLCR_RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= idx_known(awaddr_ff) ? `SLCR_RESP_OKAY : `SLCR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // pin levels are caught while reset is held, so straps must be stable then
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      link_ff <= slcr_link_ctrl_s'(`SLCR_LINK_RST_BASE);
      link_ff.serial_link_enable <= !auto_start_pin;
      link_ff.sleep_mode <= auto_start_pin && control_direction_pin;
    end else if (wr_link) begin
      link_ff <= slcr_link_ctrl_s'(wdata_ff);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      drive_ff <= slcr_drive_s'(`SLCR_DRIVE_RST);
    end else if (wr_drive) begin
      drive_ff <= slcr_drive_s'(wdata_ff);
    end
  end

  // link start or stop opens the reverse channel blackout
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      link_prev_ff <= 1'b0;
    end else begin
      link_prev_ff <= link_ff.serial_link_enable;
    end
  end

  assign link_toggle = !reset && (link_prev_ff != link_ff.serial_link_enable);

  slcr_blackout_timer #(
    .CYCLES(BLACKOUT_CYCLES)
  ) u_blackout (
    .ref_clk(ref_clk),
    .reset(reset),
    .restart(link_toggle),
    .busy(busy)
  );

  // a reset-time link enable of 1 also counts as a start, since the previous value resets to 0
  assign reverse_blackout = busy;
  assign reverse_rx_enable = link_ff.reverse_channel_enable && !busy;

  // registered decodes keep the data outputs glitch free
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      base_i2c_ff <= 1'b1; // select resets to the i2c code, so no false decode after reset
      base_uart_ff <= 1'b0;
      swing_bad_ff <= 1'b0;
      emph_ff <= '0;
    end else begin
      base_i2c_ff <= link_ff.base_peripheral_select == `SLCR_BASE_I2C;
      base_uart_ff <= link_ff.base_peripheral_select == `SLCR_BASE_UART;
      swing_bad_ff <= drive_ff.line_swing_level == `SLCR_SWING_UNUSED;
      emph_ff <= emph_decode(drive_ff.driver_emphasis_level);
    end
  end

  assign link_cfg = link_ff;
  assign drive_cfg = drive_ff;
  assign base_i2c_sel = base_i2c_ff;
  assign base_uart_sel = base_uart_ff;
  assign line_swing_invalid = swing_bad_ff;
  assign emphasis = emph_ff;

  // read channel
  assign s_axi_arready = !rvalid_ff;
  assign rd_idx = s_axi_araddr[7:2];

  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      `SLCR_IDX_LINK_CONTROL: rd_byte = link_ff;
      `SLCR_IDX_DRIVE_CONFIG: rd_byte = drive_ff;
      `SLCR_IDX_RESERVED_SIX: rd_byte = `SLCR_RESERVED_SIX_VAL;
      `SLCR_IDX_RESERVED_SEVEN: rd_byte = `SLCR_RESERVED_SEVEN_VAL;
      `SLCR_IDX_STATUS: rd_byte = {5'h00, emph_ff.reserved_code, swing_bad_ff, busy};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `SLCR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_byte};
      rresp_ff <= idx_known(s_axi_araddr) ? `SLCR_RESP_OKAY : `SLCR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // checks
  property p_link_reset_value;
    @(posedge ref_clk) $fell(reset) |-> link_ff.serial_link_enable == !$past(auto_start_pin);
  endproperty
  a_link_reset_value: assert property (p_link_reset_value) else $error("link enable reset value wrong");

  property p_link_write;
    @(posedge ref_clk) disable iff (reset)
      wr_link |=> link_ff.serial_link_enable == $past(wdata_ff[7]);
  endproperty
  a_link_write: assert property (p_link_write) else $error("link enable not written");

  property p_blackout_start;
    @(posedge ref_clk) disable iff (reset)
      $changed(link_ff.serial_link_enable) |-> ##1 (reverse_blackout && !reverse_rx_enable) [*8];
  endproperty
  a_blackout_start: assert property (p_blackout_start) else $error("reverse channel open after link change");

  property p_sleep_reset_value;
    @(posedge ref_clk) $fell(reset) |->
      link_ff.sleep_mode == ($past(auto_start_pin) && $past(control_direction_pin));
  endproperty
  a_sleep_reset_value: assert property (p_sleep_reset_value) else $error("sleep reset value wrong");

  property p_base_select;
    @(posedge ref_clk) disable iff (reset)
      ##1 (base_i2c_sel == ($past(link_ff.base_peripheral_select) == `SLCR_BASE_I2C)) &&
          (base_uart_sel == ($past(link_ff.base_peripheral_select) == `SLCR_BASE_UART));
  endproperty
  a_base_select: assert property (p_base_select) else $error("base peripheral decode wrong");

  property p_reverse_gate;
    @(posedge ref_clk) disable iff (reset)
      wr_link |=> reverse_rx_enable == ($past(wdata_ff[1]) && !reverse_blackout);
  endproperty
  a_reverse_gate: assert property (p_reverse_gate) else $error("reverse channel enabled wrongly");

  property p_ctrl_reset;
    @(posedge ref_clk) $fell(reset) |->
      link_cfg.forward_channel_enable && link_cfg.reverse_channel_enable &&
      !link_cfg.config_link_enable && !link_cfg.bit_sequence_test_enable &&
      link_cfg.base_peripheral_select == `SLCR_BASE_I2C;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("link control reset value wrong");

  property p_drive_reset;
    @(posedge ref_clk) $fell(reset) |->
      !drive_cfg.register_address_suppress && drive_cfg.filter_pll_disable &&
      drive_cfg.line_swing_level == 2'h3 && drive_cfg.driver_emphasis_level == `SLCR_EMPH_OFF;
  endproperty
  a_drive_reset: assert property (p_drive_reset) else $error("drive reset value wrong");

  property p_swing_flag;
    @(posedge ref_clk) disable iff (reset)
      wr_drive && wdata_ff[5:4] == `SLCR_SWING_UNUSED |-> ##2 line_swing_invalid;
  endproperty
  a_swing_flag: assert property (p_swing_flag) else $error("unused swing code not flagged");

  property p_emph_reserved;
    @(posedge ref_clk) disable iff (reset)
      wr_drive && wdata_ff[3:0] > `SLCR_EMPH_DEEMPH_MAX && wdata_ff[3:0] < `SLCR_EMPH_BOOST_MIN
        |-> ##2 emphasis.reserved_code && !emphasis.active;
  endproperty
  a_emph_reserved: assert property (p_emph_reserved) else $error("reserved emphasis not flagged");

  property p_write_resp;
    @(posedge ref_clk) disable iff (reset)
      do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response missing");

endmodule : slcr_regs

// [verif/slcr_host_model.sv]
// axi4-lite controller model that configures the register bank
`timescale 1ns/1ps
module slcr_host_model (
  input wire logic ref_clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic reverse_blackout
);
  // cycles before raising bready or rready, to test a slow controller
  int lag = 0;
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    n = lag;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (n == 0);
    forever begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        // released payload no longer shows the last value
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bready && s_axi_bvalid === 1'b1) break;
      if (n > 0) n--;
      s_axi_bready <= (n == 0);
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    n = lag;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (n == 0);
    forever begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rready && s_axi_rvalid === 1'b1) break;
      if (n > 0) n--;
      s_axi_rready <= (n == 0);
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // no reverse traffic is relied on until the blackout ends
  task automatic wait_rev();
    do @(posedge ref_clk); while (reverse_blackout !== 1'b0);
    // one more edge so bench monitors have taken the closing cycle
    @(posedge ref_clk);
  endtask : wait_rev
endmodule : slcr_host_model

// [verif/tb_serial_link_config_registers.sv]
// self-checking testbench for the serial link configuration registers
`timescale 1ns/1ps
`include "slcr_cfg.svh"
module tb_serial_link_config_registers
  import slcr_pkg::*;
;
  localparam int BLK = 20;
  logic ref_clk = 1'b0;
  logic reset;
  logic auto_start_pin;
  logic control_direction_pin;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [7:0] v;
  slcr_link_ctrl_s link_cfg;
  slcr_drive_s drive_cfg;
  slcr_emph_s emphasis;
  logic reverse_rx_enable, reverse_blackout, base_i2c_sel, base_uart_sel, line_swing_invalid;
  int fail_count = 0;
  int checked = 0;
  int run_ff = 0;
  int last_len_ff = 0;
  int runs_ff = 0;
  logic leak_ff = 1'b0;
  always #4 ref_clk = ~ref_clk;
  slcr_regs #(.BLACKOUT_CYCLES(BLK)) uut (.ref_clk(ref_clk), .reset(reset), .auto_start_pin(auto_start_pin),
    .control_direction_pin(control_direction_pin), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_cfg(link_cfg),
    .drive_cfg(drive_cfg), .reverse_rx_enable(reverse_rx_enable), .reverse_blackout(reverse_blackout),
    .base_i2c_sel(base_i2c_sel), .base_uart_sel(base_uart_sel), .line_swing_invalid(line_swing_invalid),
    .emphasis(emphasis));
  slcr_host_model host (.ref_clk(ref_clk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .reverse_blackout(reverse_blackout));
  // length and count of blackout windows, and any reception let through meanwhile
  always @(posedge ref_clk) begin
    if (reverse_blackout === 1'b1) begin
      run_ff <= run_ff + 1;
      if (reverse_rx_enable !== 1'b0) leak_ff <= 1'b1;
    end else if (run_ff != 0) begin
      last_len_ff <= run_ff;
      runs_ff <= runs_ff + 1;
      run_ff <= 0;
    end
  end
  function automatic logic [5:0] emph_exp(input logic [3:0] c);
    if (c == 4'h0) return 6'h00;
    if (c <= 4'h4) return {2'b10, c[2:0], 1'b0};
    if (c >= 4'h8) return {2'b11, c[2:0], 1'b0};
    return 6'h01;
  endfunction : emph_exp
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrc(input logic [7:0] a, input logic [7:0] dv);
    host.wr(a, {24'h0, dv}, r);
    chk("bresp", r, `SLCR_RESP_OKAY);
    repeat (2) @(posedge ref_clk);
  endtask : wrc
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, d, r);
    chk("rdata", d, e);
    chk("rresp", r, `SLCR_RESP_OKAY);
  endtask : rdc
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    reset = 1'b1;
    auto_start_pin = 1'b0;
    control_direction_pin = 1'b1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    rdc(8'h10, 32'h83);
    rdc(8'h14, 32'h70);
    rdc(8'h18, 32'h40);
    rdc(8'h1c, 32'h22);
    host.wait_rev();
    chk("blackout_len", last_len_ff, BLK);
    chk("rx_enable", reverse_rx_enable, 1'b1);
    // stopping the link opens a second window, also seen in the status word
    wrc(8'h10, 8'h03);
    rdc(8'h80, 32'h01);
    host.wait_rev();
    chk("blackout_runs", runs_ff, 2);
    chk("blackout_len", last_len_ff, BLK);
    wrc(8'h10, 8'h01);
    chk("rx_enable", reverse_rx_enable, 1'b0);
    chk("link_cfg", link_cfg, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wrc(8'h10, 8'h03 | (8'(i) << 2));
      chk("base_i2c", base_i2c_sel, i == 0);
      chk("base_uart", base_uart_sel, i == 1);
    end
    wrc(8'h10, 8'h73);
    rdc(8'h10, 32'h73);
    chk("link_cfg", link_cfg, 8'h73);
    host.lag = 3;
    for (int i = 0; i < 4; i++) begin
      v = 8'(i) << 4;
      wrc(8'h14, v);
      chk("swing_invalid", line_swing_invalid, i == 0);
      chk("drive_cfg", drive_cfg, v);
    end
    for (int i = 0; i < 16; i++) begin
      wrc(8'h14, 8'h30 | 8'(i));
      chk("emphasis", emphasis, emph_exp(4'(i)));
    end
    host.lag = 0;
    wrc(8'h14, 8'h80);
    rdc(8'h14, 32'h80);
    chk("addr_suppress", drive_cfg.register_address_suppress, 1'b1);
    // byte lane 0 off: the write is answered but nothing is stored
    host.s_axi_wstrb <= 4'h0;
    wrc(8'h14, 8'h00);
    rdc(8'h14, 32'h80);
    host.s_axi_wstrb <= 4'h1;
    wrc(8'h18, 8'hff);
    rdc(8'h18, 32'h40);
    host.wr(8'h3c, 32'h5a, r);
    chk("bresp", r, `SLCR_RESP_SLVERR);
    host.rd(8'h3c, d, r);
    chk("rdata", d, 32'h0);
    chk("rresp", r, `SLCR_RESP_SLVERR);
    // auto-start strap set, control direction strap left high, gives link stopped and sleep set
    @(posedge ref_clk);
    auto_start_pin <= 1'b1;
    reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    rdc(8'h10, 32'h13);
    chk("rx_leak", leak_ff, 1'b0);
    report_and_stop();
  end
endmodule : tb_serial_link_config_registers
